/* File: design/icf_pkg.sv */
// Constants and carrier types of the interrupt control and flag registers
package icf_pkg;

    // ==================================================
    // Register byte addresses
    localparam logic [7:0] ICF_OFS_EDGE = 8'h00;
    localparam logic [7:0] ICF_OFS_CTL0 = 8'h04;
    localparam logic [7:0] ICF_OFS_CTL1 = 8'h08;
    localparam logic [7:0] ICF_OFS_CTL2 = 8'h0C;
    localparam logic [7:0] ICF_OFS_EVT_STAT = 8'h10;
    localparam logic [7:0] ICF_OFS_EVT_MASK = 8'h14;

    // ==================================================
    // Reset values
    localparam logic [7:0] ICF_RST_BYTE = 8'h00;
    localparam logic [8:0] ICF_RST_SRC = 9'h000;

    // ==================================================
    // Edge-select field positions and codes
    localparam int ICF_EDGE_PIN0_LSB = 0;
    localparam int ICF_EDGE_PIN1_LSB = 2;
    localparam logic [1:0] ICF_EDGE_OFF = 2'h0;
    localparam logic [1:0] ICF_EDGE_RISE = 2'h1;
    localparam logic [1:0] ICF_EDGE_FALL = 2'h2;
    localparam logic [1:0] ICF_EDGE_BOTH = 2'h3;

    // ==================================================
    // First control register bit positions
    localparam int ICF_C0_GLOBAL_EN = 0;
    localparam int ICF_C0_PIN0_EN = 1;
    localparam int ICF_C0_PIN1_EN = 2;
    localparam int ICF_C0_SERIAL_EN = 3;
    localparam int ICF_C0_PIN0_FLAG = 4;
    localparam int ICF_C0_PIN1_FLAG = 5;
    localparam int ICF_C0_SERIAL_FLAG = 6;

    // ==================================================
    // Second control register bit positions
    localparam int ICF_C1_GRP2_EN = 0;
    localparam int ICF_C1_GRP0_EN = 1;
    localparam int ICF_C1_GRP1_EN = 2;
    localparam int ICF_C1_CONV_EN = 3;
    localparam int ICF_C1_GRP2_FLAG = 4;
    localparam int ICF_C1_GRP0_FLAG = 5;
    localparam int ICF_C1_GRP1_FLAG = 6;
    localparam int ICF_C1_CONV_FLAG = 7;

    // ==================================================
    // Time-base register bit positions
    localparam int ICF_C2_TICK0_EN = 0;
    localparam int ICF_C2_TICK1_EN = 1;
    localparam int ICF_C2_TICK0_FLAG = 4;
    localparam int ICF_C2_TICK1_FLAG = 5;

    // ==================================================
    // Source index in flag, enable, status and mask vectors
    localparam int ICF_NSRC = 9;
    localparam int ICF_SRC_PIN0 = 0;
    localparam int ICF_SRC_PIN1 = 1;
    localparam int ICF_SRC_SERIAL = 2;
    localparam int ICF_SRC_CONV = 3;
    localparam int ICF_SRC_GRP0 = 4;
    localparam int ICF_SRC_GRP1 = 5;
    localparam int ICF_SRC_GRP2 = 6;
    localparam int ICF_SRC_TICK0 = 7;
    localparam int ICF_SRC_TICK1 = 8;

    // Request pulses from the on-chip sources
    typedef struct packed {
        logic serial_if;
        logic converter;
        logic [2:0] group;
        logic [1:0] tick;
    } icf_src_evt_t;

endpackage

/* File: design/icf_pin_edge.sv */
// Pin synchroniser and selectable edge detector
`timescale 1ns/1ns
`default_nettype none
module icf_pin_edge (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic [1:0] edge_sel_i,
    output logic hit_o
);
    import icf_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise;
    logic fall;

    // ==================================================
    // Two-stage synchroniser, then one history stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // ==================================================
    // Edge selection
    always_comb begin
        case (edge_sel_i)
            ICF_EDGE_OFF: hit_o = 1'b0;
            ICF_EDGE_RISE: hit_o = rise;
            ICF_EDGE_FALL: hit_o = fall;
            ICF_EDGE_BOTH: hit_o = rise | fall;
            default: hit_o = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

/* File: design/icf_req_flag.sv */
// One request flag: set by hardware, written by software, set wins
`timescale 1ns/1ns
`default_nettype none
module icf_req_flag (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic q_o
);
    import icf_pkg::*;

    logic q_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= 1'b0;
        end else if (set_i) begin
            q_r <= 1'b1;
        end else if (wr_i) begin
            q_r <= wdata_i;
        end
    end

    assign q_o = q_r;

endmodule
`default_nettype wire

/* File: design/icf_irq_ctrl.sv */
// Interrupt controller control and flag registers with APB slave
`timescale 1ns/1ns
`default_nettype none
module icf_irq_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Sources
    input wire logic ext_pin_zero_i,
    input wire logic ext_pin_one_i,
    input wire icf_pkg::icf_src_evt_t src_evt_i,
    // Towards the CPU
    output logic [icf_pkg::ICF_NSRC-1:0] irq_req_o,
    output logic cpu_irq_o,
    output logic evt_irq_o
);
    import icf_pkg::*;

    // ==================================================
    // Declarations
    logic [3:0] edge_sel_r;
    logic global_irq_en_r;
    logic [ICF_NSRC-1:0] src_en_r;
    logic [ICF_NSRC-1:0] flag;
    logic [ICF_NSRC-1:0] flag_set;
    logic [ICF_NSRC-1:0] flag_wr;
    logic [ICF_NSRC-1:0] flag_wd;
    logic [ICF_NSRC-1:0] evt_stat_r;
    logic [ICF_NSRC-1:0] evt_mask_r;
    logic [ICF_NSRC-1:0] irq_req_r;
    logic cpu_irq_r;
    logic evt_irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic pin0_hit;
    logic pin1_hit;
    logic setup_ph;
    logic wr_acc;
    logic byte0_wr;
    logic [7:0] wb;
    logic hit_edge;
    logic hit_c0;
    logic hit_c1;
    logic hit_c2;
    logic hit_stat;
    logic hit_mask;
    logic addr_ok;
    logic [31:0] rdata_nxt;
    logic [7:0] edge_rd;
    logic [7:0] c0_rd;
    logic [7:0] c1_rd;
    logic [7:0] c2_rd;

    // ==================================================
    // APB decode
    assign setup_ph = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;
    assign byte0_wr = wr_acc & pstrb_i[0];
    assign wb = pwdata_i[7:0];
    assign hit_edge = (paddr_i == ICF_OFS_EDGE);
    assign hit_c0 = (paddr_i == ICF_OFS_CTL0);
    assign hit_c1 = (paddr_i == ICF_OFS_CTL1);
    assign hit_c2 = (paddr_i == ICF_OFS_CTL2);
    assign hit_stat = (paddr_i == ICF_OFS_EVT_STAT);
    assign hit_mask = (paddr_i == ICF_OFS_EVT_MASK);
    assign addr_ok = hit_edge | hit_c0 | hit_c1 | hit_c2 | hit_stat | hit_mask;

    // ==================================================
    // External pin edge detection
    icf_pin_edge u_pin0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_pin_zero_i),
        .edge_sel_i(edge_sel_r[ICF_EDGE_PIN0_LSB +: 2]),
        .hit_o(pin0_hit)
    );
    icf_pin_edge u_pin1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_pin_one_i),
        .edge_sel_i(edge_sel_r[ICF_EDGE_PIN1_LSB +: 2]),
        .hit_o(pin1_hit)
    );

    // ==================================================
    // Edge-select register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_sel_r <= ICF_RST_BYTE[3:0];
        end else if (byte0_wr && hit_edge) begin
            edge_sel_r <= wb[3:0];
        end
    end

    // ==================================================
    // Global and per-source enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_en_r <= 1'b0;
        end else if (byte0_wr && hit_c0) begin
            global_irq_en_r <= wb[ICF_C0_GLOBAL_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_en_r <= ICF_RST_SRC;
        end else if (byte0_wr) begin
            if (hit_c0) begin
                src_en_r[ICF_SRC_PIN0] <= wb[ICF_C0_PIN0_EN];
                src_en_r[ICF_SRC_PIN1] <= wb[ICF_C0_PIN1_EN];
                src_en_r[ICF_SRC_SERIAL] <= wb[ICF_C0_SERIAL_EN];
            end
            if (hit_c1) begin
                src_en_r[ICF_SRC_GRP2] <= wb[ICF_C1_GRP2_EN];
                src_en_r[ICF_SRC_GRP0] <= wb[ICF_C1_GRP0_EN];
                src_en_r[ICF_SRC_GRP1] <= wb[ICF_C1_GRP1_EN];
                src_en_r[ICF_SRC_CONV] <= wb[ICF_C1_CONV_EN];
            end
            if (hit_c2) begin
                src_en_r[ICF_SRC_TICK0] <= wb[ICF_C2_TICK0_EN];
                src_en_r[ICF_SRC_TICK1] <= wb[ICF_C2_TICK1_EN];
            end
        end
    end

    // ==================================================
    // Request flag set and write terms
    always_comb begin
        flag_set = '0;
        flag_set[ICF_SRC_PIN0] = pin0_hit;
        flag_set[ICF_SRC_PIN1] = pin1_hit;
        flag_set[ICF_SRC_SERIAL] = src_evt_i.serial_if;
        flag_set[ICF_SRC_CONV] = src_evt_i.converter;
        flag_set[ICF_SRC_GRP0] = src_evt_i.group[0];
        flag_set[ICF_SRC_GRP1] = src_evt_i.group[1];
        flag_set[ICF_SRC_GRP2] = src_evt_i.group[2];
        flag_set[ICF_SRC_TICK0] = src_evt_i.tick[0];
        flag_set[ICF_SRC_TICK1] = src_evt_i.tick[1];
    end

    always_comb begin
        flag_wr = '0;
        flag_wr[ICF_SRC_PIN0] = byte0_wr & hit_c0;
        flag_wr[ICF_SRC_PIN1] = byte0_wr & hit_c0;
        flag_wr[ICF_SRC_SERIAL] = byte0_wr & hit_c0;
        flag_wr[ICF_SRC_CONV] = byte0_wr & hit_c1;
        flag_wr[ICF_SRC_GRP0] = byte0_wr & hit_c1;
        flag_wr[ICF_SRC_GRP1] = byte0_wr & hit_c1;
        flag_wr[ICF_SRC_GRP2] = byte0_wr & hit_c1;
        flag_wr[ICF_SRC_TICK0] = byte0_wr & hit_c2;
        flag_wr[ICF_SRC_TICK1] = byte0_wr & hit_c2;
    end

    always_comb begin
        flag_wd = '0;
        flag_wd[ICF_SRC_PIN0] = wb[ICF_C0_PIN0_FLAG];
        flag_wd[ICF_SRC_PIN1] = wb[ICF_C0_PIN1_FLAG];
        flag_wd[ICF_SRC_SERIAL] = wb[ICF_C0_SERIAL_FLAG];
        flag_wd[ICF_SRC_CONV] = wb[ICF_C1_CONV_FLAG];
        flag_wd[ICF_SRC_GRP0] = wb[ICF_C1_GRP0_FLAG];
        flag_wd[ICF_SRC_GRP1] = wb[ICF_C1_GRP1_FLAG];
        flag_wd[ICF_SRC_GRP2] = wb[ICF_C1_GRP2_FLAG];
        flag_wd[ICF_SRC_TICK0] = wb[ICF_C2_TICK0_FLAG];
        flag_wd[ICF_SRC_TICK1] = wb[ICF_C2_TICK1_FLAG];
    end

    // ==================================================
    // Flags stay set until software writes zero
    genvar gi;
    generate
        for (gi = 0; gi < ICF_NSRC; gi++) begin : g_flag
            icf_req_flag u_flag (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .set_i(flag_set[gi]),
                .wr_i(flag_wr[gi]),
                .wdata_i(flag_wd[gi]),
                .q_o(flag[gi])
            );
        end
    endgenerate

    // ==================================================
    // Event status (write one to clear, set wins)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_stat_r <= ICF_RST_SRC;
        end else if (byte0_wr && hit_stat) begin
            evt_stat_r <= (evt_stat_r & ~{pwdata_i[ICF_NSRC-1:0]}) | flag_set;
        end else begin
            evt_stat_r <= evt_stat_r | flag_set;
        end
    end

    // ==================================================
    // Event mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_mask_r <= ICF_RST_SRC;
        end else if (byte0_wr && hit_mask) begin
            evt_mask_r <= pwdata_i[ICF_NSRC-1:0];
        end
    end

    // ==================================================
    // Interrupt outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_r <= ICF_RST_SRC;
        end else begin
            irq_req_r <= flag & src_en_r & {ICF_NSRC{global_irq_en_r}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_r <= 1'b0;
        end else begin
            cpu_irq_r <= global_irq_en_r & |(flag & src_en_r);
        end
    end

    // ==================================================
    // Event interrupt: any unmasked status bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_irq_r <= 1'b0;
        end else begin
            evt_irq_r <= |(evt_stat_r & evt_mask_r);
        end
    end

    // ==================================================
    // Read views
    always_comb begin
        edge_rd = '0;
        edge_rd[3:0] = edge_sel_r;
        c0_rd = '0;
        c0_rd[ICF_C0_GLOBAL_EN] = global_irq_en_r;
        c0_rd[ICF_C0_PIN0_EN] = src_en_r[ICF_SRC_PIN0];
        c0_rd[ICF_C0_PIN1_EN] = src_en_r[ICF_SRC_PIN1];
        c0_rd[ICF_C0_SERIAL_EN] = src_en_r[ICF_SRC_SERIAL];
        c0_rd[ICF_C0_PIN0_FLAG] = flag[ICF_SRC_PIN0];
        c0_rd[ICF_C0_PIN1_FLAG] = flag[ICF_SRC_PIN1];
        c0_rd[ICF_C0_SERIAL_FLAG] = flag[ICF_SRC_SERIAL];
        c1_rd = '0;
        c1_rd[ICF_C1_GRP2_EN] = src_en_r[ICF_SRC_GRP2];
        c1_rd[ICF_C1_GRP0_EN] = src_en_r[ICF_SRC_GRP0];
        c1_rd[ICF_C1_GRP1_EN] = src_en_r[ICF_SRC_GRP1];
        c1_rd[ICF_C1_CONV_EN] = src_en_r[ICF_SRC_CONV];
        c1_rd[ICF_C1_GRP2_FLAG] = flag[ICF_SRC_GRP2];
        c1_rd[ICF_C1_GRP0_FLAG] = flag[ICF_SRC_GRP0];
        c1_rd[ICF_C1_GRP1_FLAG] = flag[ICF_SRC_GRP1];
        c1_rd[ICF_C1_CONV_FLAG] = flag[ICF_SRC_CONV];
        c2_rd = '0;
        c2_rd[ICF_C2_TICK0_EN] = src_en_r[ICF_SRC_TICK0];
        c2_rd[ICF_C2_TICK1_EN] = src_en_r[ICF_SRC_TICK1];
        c2_rd[ICF_C2_TICK0_FLAG] = flag[ICF_SRC_TICK0];
        c2_rd[ICF_C2_TICK1_FLAG] = flag[ICF_SRC_TICK1];
    end

    // ==================================================
    // Read data select
    always_comb begin
        rdata_nxt = '0;
        if (hit_edge) begin
            rdata_nxt[7:0] = edge_rd;
        end else if (hit_c0) begin
            rdata_nxt[7:0] = c0_rd;
        end else if (hit_c1) begin
            rdata_nxt[7:0] = c1_rd;
        end else if (hit_c2) begin
            rdata_nxt[7:0] = c2_rd;
        end else if (hit_stat) begin
            rdata_nxt[ICF_NSRC-1:0] = evt_stat_r;
        end else if (hit_mask) begin
            rdata_nxt[ICF_NSRC-1:0] = evt_mask_r;
        end
    end

    // ==================================================
    // APB answer: ready in the first access cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= setup_ph & ~addr_ok;
        end
    end

    // ==================================================
    // Read data captured at the setup edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_r <= '0;
        end else if (setup_ph && !pwrite_i) begin
            prdata_r <= rdata_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign irq_req_o = irq_req_r;
    assign cpu_irq_o = cpu_irq_r;
    assign evt_irq_o = evt_irq_r;

endmodule
`default_nettype wire

/* File: verification/icf_src_model.sv */
// Model of the interrupt sources: two pins and on-chip request pulses
`timescale 1ns/1ns
`default_nettype none
module icf_src_model
    import icf_pkg::*;
(
    input wire logic clk_i,
    output logic pin_zero_o,
    output logic pin_one_o,
    output icf_pkg::icf_src_evt_t evt_o
);
    initial begin
        pin_zero_o = 1'b0;
        pin_one_o = 1'b0;
        evt_o = '0;
    end
    // ==========
    // Pin level, held until changed
    task automatic set_pin(input int p, input logic lvl);
        @(posedge clk_i);
        if (p == 0) begin
            pin_zero_o <= lvl;
        end else begin
            pin_one_o <= lvl;
        end
    endtask
    // ==========
    // One-cycle request on {serial, converter, group[2:0], tick[1:0]}
    task automatic pulse(input logic [6:0] m);
        @(posedge clk_i);
        evt_o <= icf_src_evt_t'(m);
        @(posedge clk_i);
        evt_o <= '0;
    endtask
endmodule
`default_nettype wire

/* File: verification/icf_irq_ctrl_monitor.sv */
// Port checks of the interrupt control and flag registers
`timescale 1ns/1ns
`default_nettype none
module icf_irq_ctrl_monitor
    import icf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic ext_pin_zero_i,
    input wire logic ext_pin_one_i,
    input wire icf_pkg::icf_src_evt_t src_evt_i,
    input wire logic [icf_pkg::ICF_NSRC-1:0] irq_req_o,
    input wire logic cpu_irq_o,
    input wire logic evt_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Bus
    ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    ready_single_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    unmapped_err_a: assert property (psel_i && !penable_i && paddr_i > ICF_OFS_EVT_MASK
        |=> pslverr_o) else $error("no error on unmapped address");
    // ==========
    // Register contents
    edge_upper_zero_a: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == ICF_OFS_EDGE
        |=> prdata_o[31:4] == 28'h0) else $error("edge register upper bits set");
    tick_gaps_zero_a: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == ICF_OFS_CTL2
        |=> prdata_o[7:6] == 2'h0 && prdata_o[3:2] == 2'h0)
        else $error("time-base gaps set");
    // ==========
    // Forwarding
    cpu_or_a: assert property (cpu_irq_o == (|irq_req_o))
        else $error("cpu irq differs from request or");
    global_off_a: assert property (
        psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
        && paddr_i == ICF_OFS_CTL0 && !pwdata_i[0] |-> ##2 irq_req_o == 9'h000)
        else $error("request with global enable off");
    flag_sticky_a: assert property (
        !$past(psel_i && penable_i && pwrite_i, 2)
        |-> ($past(irq_req_o) & ~irq_req_o) == 9'h000)
        else $error("request dropped without write");
    tick_cause_a: assert property (
        $rose(irq_req_o[ICF_SRC_TICK0])
        |-> $past(src_evt_i.tick[0], 2) || $past(psel_i && penable_i && pwrite_i, 2))
        else $error("tick request without cause");
    conv_cause_a: assert property (
        $rose(irq_req_o[ICF_SRC_CONV])
        |-> $past(src_evt_i.converter, 2) || $past(psel_i && penable_i && pwrite_i, 2))
        else $error("converter request without cause");
endmodule
`default_nettype wire

/* File: verification/irq_control_flag_registers_test.sv */
// Testbench of the interrupt control and flag registers
`timescale 1ns/1ns
`default_nettype none
`define ICF_CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("unexpected %s expected %h seen %h", nm, (e), (g)); \
        end \
    end
module irq_control_flag_registers_test;
    import icf_pkg::*;
    logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q;
    logic [3:0] pstrb_i;
    logic ext_pin_zero_i, ext_pin_one_i, cpu_irq_o, evt_irq_o;
    icf_src_evt_t src_evt_i;
    logic [ICF_NSRC-1:0] irq_req_o;
    int bad_count = 0;
    int n_compared = 0;
    logic [7:0] reg_adr [4] = '{ICF_OFS_EDGE, ICF_OFS_CTL0, ICF_OFS_CTL1, ICF_OFS_CTL2};
    logic [7:0] reg_all [4] = '{8'h0F, 8'h7F, 8'hFF, 8'h33};
    logic [7:0] src_adr [7] = '{ICF_OFS_CTL2, ICF_OFS_CTL2, ICF_OFS_CTL1, ICF_OFS_CTL1,
        ICF_OFS_CTL1, ICF_OFS_CTL1, ICF_OFS_CTL0};
    int src_bit [7] = '{4, 5, 5, 6, 4, 7, 6};
    int src_idx [7] = '{ICF_SRC_TICK0, ICF_SRC_TICK1, ICF_SRC_GRP0, ICF_SRC_GRP1,
        ICF_SRC_GRP2, ICF_SRC_CONV, ICF_SRC_SERIAL};
    icf_irq_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ext_pin_zero_i(ext_pin_zero_i), .ext_pin_one_i(ext_pin_one_i),
        .src_evt_i(src_evt_i), .irq_req_o(irq_req_o), .cpu_irq_o(cpu_irq_o),
        .evt_irq_o(evt_irq_o));
    icf_src_model src_u (.clk_i(clk_i), .pin_zero_o(ext_pin_zero_i),
        .pin_one_o(ext_pin_one_i), .evt_o(src_evt_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // ==========
    // Bus access and closing
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        end_sim();
    end
    // ==========
    // Tests
    initial begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i));
            `ICF_CHK("reset value", 32'h0, q)
            `ICF_CHK("mapped error", 1'b0, err)
        end
        rd(8'h18);
        `ICF_CHK("unmapped read", 1'b1, err)
        for (int i = 0; i < 4; i++) begin
            wr(reg_adr[i], 32'hFFFF_FFFF);
            rd(reg_adr[i]);
            `ICF_CHK("readback", {24'h0, reg_all[i]}, q)
            wr(reg_adr[i], 32'h0);
            rd(reg_adr[i]);
            `ICF_CHK("cleared", 32'h0, q)
        end
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr(ICF_OFS_EDGE, 32'(c << (2 * p)));
                src_u.set_pin(p, 1'b1);
                repeat (6) @(posedge clk_i);
                rd(ICF_OFS_CTL0);
                `ICF_CHK("pin rise", c[0], q[4 + p])
                wr(ICF_OFS_CTL0, 32'h0);
                src_u.set_pin(p, 1'b0);
                repeat (6) @(posedge clk_i);
                rd(ICF_OFS_CTL0);
                `ICF_CHK("pin fall", c[1], q[4 + p])
                wr(ICF_OFS_CTL0, 32'h0);
            end
        end
        wr(ICF_OFS_CTL0, 32'h1);
        wr(ICF_OFS_CTL2, 32'h1);
        src_u.pulse(7'h01);
        repeat (2) @(negedge clk_i);
        `ICF_CHK("irq request", 9'h080, irq_req_o)
        `ICF_CHK("cpu irq", 1'b1, cpu_irq_o)
        wr(ICF_OFS_CTL0, 32'h0);
        repeat (2) @(negedge clk_i);
        `ICF_CHK("cpu irq gated", 1'b0, cpu_irq_o)
        rd(ICF_OFS_CTL2);
        `ICF_CHK("sticky flag", 32'h11, q)
        wr(ICF_OFS_CTL2, 32'h0);
        wr(ICF_OFS_EVT_STAT, 32'h1FF);
        for (int i = 0; i < 7; i++) begin
            src_u.pulse(7'(1 << i));
            rd(src_adr[i]);
            `ICF_CHK("source flag", 32'(1 << src_bit[i]), q)
            rd(ICF_OFS_EVT_STAT);
            `ICF_CHK("event status", 32'(1 << src_idx[i]), q)
            wr(ICF_OFS_EVT_STAT, 32'(1 << src_idx[i]));
            wr(src_adr[i], 32'h0);
        end
        rd(ICF_OFS_EVT_STAT);
        `ICF_CHK("status cleared", 32'h0, q)
        src_u.pulse(7'h20);
        repeat (3) @(negedge clk_i);
        `ICF_CHK("event masked", 1'b0, evt_irq_o)
        wr(ICF_OFS_EVT_MASK, 32'h8);
        repeat (3) @(negedge clk_i);
        `ICF_CHK("event irq", 1'b1, evt_irq_o)
        wr(ICF_OFS_EVT_STAT, 32'h8);
        repeat (3) @(negedge clk_i);
        `ICF_CHK("event cleared", 1'b0, evt_irq_o)
        end_sim();
    end
endmodule
bind icf_irq_ctrl icf_irq_ctrl_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ext_pin_zero_i(ext_pin_zero_i), .ext_pin_one_i(ext_pin_one_i),
    .src_evt_i(src_evt_i), .irq_req_o(irq_req_o), .cpu_irq_o(cpu_irq_o),
    .evt_irq_o(evt_irq_o));
`default_nettype wire
